// *** design/flash_status_register_map.sv ***
// Status register, protection check and sector decode of a serial flash
`timescale 1ns/1ps
module flash_status_register_map
  import flash_status_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic clk, // 20 MHz system clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic cs_n, // Chip select, low selects
  input wire logic sck_rise, // Link clock rising edge strobe
  input wire logic sck_fall, // Link clock falling edge strobe
  input wire logic si, // Serial data in
  input wire logic wp_n, // Write protect pin level
  input wire logic pause_n, // Pause pin level
  input wire logic [ADDR_W-1:0] check_addr, // Address to classify
  input wire logic write_done, // Program or erase engine finished
  output logic so, // Serial data out
  output logic so_oe, // Serial data out enable
  output logic [7:0] status, // Status register view
  output logic quad_mode, // Pins 2 and 3 act as data
  output logic wp_active, // Protect pin acts as control
  output logic paused, // Pause function active
  output logic [SECTOR_W-1:0] sector_index, // Sector of check_addr
  output logic [BLK32_W-1:0] block32_index, // 32 KB block of check_addr
  output logic [BLK64_W-1:0] block64_index, // 64 KB block of check_addr
  output logic addr_protected // check_addr lies in a protected area
);

  typedef struct packed {
    logic [7:0] status;
    phase_t phase;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [7:0] out_byte;
    logic so;
    logic so_oe;
    logic [15:0] busy_cnt;
    logic quad_mode;
    logic wp_active;
    logic paused;
    logic [SECTOR_W-1:0] sector_index;
    logic [BLK32_W-1:0] block32_index;
    logic [BLK64_W-1:0] block64_index;
    logic addr_protected;
  } state_t;

  state_t r;
  state_t next_r;

  // Top-area protection: level n covers the top 2^(n-1) 64 KB blocks
  function automatic logic in_protected(input logic [3:0] level,
                                        input logic [BLK64_W-1:0] blk);
    logic [BLK64_W:0] span;
    logic [BLK64_W:0] first;
    span = '0;
    first = '0;
    if (level == 4'h0) begin
      in_protected = 1'b0;
    end else if (level >= BP_ALL) begin
      in_protected = 1'b1;
    end else begin
      span = (BLK64_W+1)'(1) << (level - 4'h1);
      first = (BLK64_W+1)'(1) << BLK64_W;
      first = first - span;
      in_protected = {1'b0, blk} >= first;
    end
  endfunction

  // Sector, 32 KB block and 64 KB block are plain upper-bit slices
  function automatic logic [SECTOR_W-1:0] sector_of(
    input logic [ADDR_W-1:0] addr);
    sector_of = addr[ADDR_W-1:SECTOR_LSB];
  endfunction

  function automatic logic [BLK32_W-1:0] block32_of(
    input logic [ADDR_W-1:0] addr);
    block32_of = addr[ADDR_W-1:BLK32_LSB];
  endfunction

  function automatic logic [BLK64_W-1:0] block64_of(
    input logic [ADDR_W-1:0] addr);
    block64_of = addr[ADDR_W-1:BLK64_LSB];
  endfunction

  // Protection level field of a status value
  function automatic logic [3:0] level_of(input logic [7:0] value);
    level_of = value[BP_HI:BP_LO];
  endfunction

  // A status write takes only the non-volatile bits; the latch stays as
  // it was and busy starts the internal write cycle
  function automatic logic [7:0] merge_write(input logic [7:0] old,
                                             input logic [7:0] data);
    logic [7:0] merged;
    merged = old;
    merged[LOCK_BIT] = data[LOCK_BIT];
    merged[QE_BIT] = data[QE_BIT];
    merged[BP_HI:BP_LO] = data[BP_HI:BP_LO];
    merged[WEL_BIT] = old[WEL_BIT];
    merged[BUSY_BIT] = 1'b1;
    merge_write = merged;
  endfunction

  // Serial bit at a given position of a byte, MSB leaves first
  function automatic logic bit_at(input logic [7:0] value,
                                  input logic [2:0] pos);
    bit_at = value[BIT_LAST - pos];
  endfunction

  // Command byte comparison
  function automatic logic is_code(input logic [7:0] value,
                                   input logic [7:0] code);
    is_code = value == code;
  endfunction

  // Bit counter wraps after the eighth bit of each byte
  function automatic logic [2:0] bump(input logic [2:0] cnt);
    bump = cnt + 3'h1;
  endfunction

  function automatic logic [15:0] load_count();
    load_count = 16'(WRITE_CYCLES);
  endfunction

  // Pause only matters while selected and while the pin is not data
  function automatic logic pin_paused(input logic quad,
                                      input logic pause_pin_n,
                                      input logic sel_n);
    pin_paused = !quad && !pause_pin_n && !sel_n;
  endfunction

  // Serial input enters at the bottom, MSB first
  function automatic logic [7:0] rx_shift(input logic [7:0] shift,
                                          input logic din);
    rx_shift = {shift[6:0], din};
  endfunction

  // Pin roles and the frame qualifiers
  logic quad_on;
  logic status_locked;
  logic link_live;
  logic rise_ok;
  logic fall_ok;
  logic byte_done;
  logic read_phase;
  logic [7:0] rx_byte;
  logic is_read_cmd;
  logic is_set_cmd;
  logic is_clr_cmd;
  logic is_write_cmd;
  logic write_ok;
  logic busy_now;
  logic busy_over;
  logic cmd_refused;

  assign quad_on = r.status[QE_BIT];
  // Once quad enable steals the protect pin, it no longer locks status
  assign status_locked = r.status[LOCK_BIT] && !wp_n && !quad_on;
  assign link_live = !cs_n && !r.paused;
  assign rise_ok = link_live && sck_rise;
  assign fall_ok = link_live && sck_fall;
  assign byte_done = rise_ok && r.bit_cnt == BIT_LAST;
  assign read_phase = r.phase == PH_READ;
  assign rx_byte = rx_shift(r.shift, si);
  assign is_read_cmd = is_code(rx_byte, CMD_READ_STATUS);
  assign is_set_cmd = is_code(rx_byte, CMD_SET_WEL);
  assign is_clr_cmd = is_code(rx_byte, CMD_CLR_WEL);
  assign is_write_cmd = is_code(rx_byte, CMD_STATUS_WRITE);
  // A status write needs the latch set and the lock not engaged
  assign write_ok = is_write_cmd && r.status[WEL_BIT] && !status_locked;
  assign busy_now = r.status[BUSY_BIT];
  // Nothing but a status read is taken while busy
  assign cmd_refused = busy_now && !is_read_cmd;
  // The timer bounds the cycle if the engine never reports completion
  assign busy_over = busy_now && (write_done || r.busy_cnt == 16'h0000);

  always_comb begin
    next_r = r;

    // Pin functions follow quad enable one cycle later
    next_r.quad_mode = quad_on;
    next_r.wp_active = !quad_on;
    next_r.paused = pin_paused(quad_on, pause_n, cs_n);

    // Address classification, registered
    next_r.sector_index = sector_of(check_addr);
    next_r.block32_index = block32_of(check_addr);
    next_r.block64_index = block64_of(check_addr);
    next_r.addr_protected = in_protected(level_of(r.status),
      block64_of(check_addr));

    // Internal write cycle: busy until the engine or the timer ends it
    if (busy_over) begin
      next_r.status[BUSY_BIT] = 1'b0;
      next_r.status[WEL_BIT] = 1'b0;
    end else if (busy_now) begin
      next_r.busy_cnt = r.busy_cnt - 16'h0001;
    end

    // Deselect ends the frame; a partial byte is dropped
    if (cs_n) begin
      next_r.phase = PH_CMD;
      next_r.bit_cnt = BIT_FIRST;
      next_r.so_oe = 1'b0;
      next_r.so = 1'b0;
    end

    // Input side: shift on every accepted rising strobe
    if (rise_ok) begin
      next_r.shift = rx_byte;
      next_r.bit_cnt = bump(r.bit_cnt);
    end

    // Byte boundary: act on the command or the data byte
    if (byte_done) begin
      case (r.phase)
        PH_CMD: begin
          next_r.phase = PH_IGNORE;
          if (is_read_cmd) begin
            next_r.phase = PH_READ;
            next_r.out_byte = r.status;
          end else if (cmd_refused) begin
            next_r.phase = PH_IGNORE;
          end else if (is_set_cmd) begin
            next_r.status[WEL_BIT] = 1'b1;
          end else if (is_clr_cmd) begin
            next_r.status[WEL_BIT] = 1'b0;
          end else if (write_ok) begin
            next_r.phase = PH_WDATA;
          end else begin
            next_r.phase = PH_IGNORE;
          end
        end
        PH_WDATA: begin
          next_r.status = merge_write(r.status, rx_byte);
          next_r.busy_cnt = load_count();
          next_r.phase = PH_IGNORE;
        end
        PH_READ: begin
          next_r.out_byte = r.status;
        end
        PH_IGNORE: begin
          next_r.phase = PH_IGNORE;
        end
        default: begin
          next_r.phase = PH_IGNORE;
        end
      endcase
    end

    // Output side: the read byte repeats, refreshed at each boundary
    if (fall_ok && read_phase) begin
      next_r.so = bit_at(r.out_byte, r.bit_cnt);
      next_r.so_oe = 1'b1;
      if (r.bit_cnt == BIT_FIRST) begin
        // Fresh copy so a busy flag that drops mid-read is seen next byte
        next_r.out_byte = r.status;
        next_r.so = r.status[BIT_LAST];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.status <= STATUS_RESET;
      r.phase <= PH_CMD;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a plain register copy
  assign so = r.so;
  assign so_oe = r.so_oe;
  assign status = r.status;

  // Pin roles
  assign quad_mode = r.quad_mode;
  assign wp_active = r.wp_active;
  assign paused = r.paused;

  // Address map
  assign sector_index = r.sector_index;
  assign block32_index = r.block32_index;
  assign block64_index = r.block64_index;
  assign addr_protected = r.addr_protected;

endmodule

// *** design/flash_status_pkg.sv ***
// Constants for the serial flash status register and address map
package flash_status_pkg;
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;
  localparam int SECTOR_W = ADDR_W - SECTOR_LSB;
  localparam int BLK32_W = ADDR_W - BLK32_LSB;
  localparam int BLK64_W = ADDR_W - BLK64_LSB;
  localparam int LOCK_BIT = 7;
  localparam int QE_BIT = 6;
  localparam int BP_HI = 5;
  localparam int BP_LO = 2;
  localparam int WEL_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CMD_SET_WEL = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [3:0] BP_ALL = 4'h9;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int WRITE_CYCLES_DEF = 16;
  typedef enum logic [1:0] {
    PH_CMD,
    PH_READ,
    PH_WDATA,
    PH_IGNORE
  } phase_t;
endpackage

// *** testbench/flash_status_assertions.sv ***
// Port assertions for the flash status block
`timescale 1ns/1ps
module flash_status_checker
  import flash_status_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic wp_n, // protect pin
  input wire logic [ADDR_W-1:0] check_addr, // address
  input wire logic [7:0] status, // status
  input wire logic quad_mode, // quad flag
  input wire logic [SECTOR_W-1:0] sector_index, // sector
  input wire logic [BLK32_W-1:0] block32_index, // 32K block
  input wire logic [BLK64_W-1:0] block64_index, // 64K block
  input wire logic addr_protected // protected
);
  localparam int BUSY_MAX = 40;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rst_clear: assert property (disable iff (1'b0)
    sys_rst |=> status == 8'h00) else $error("status not reset");
  a_sector_dec: assert property (!$past(sys_rst) |->
    sector_index == $past(check_addr[23:12])) else $error("bad sector");
  a_block32_dec: assert property (!$past(sys_rst) |->
    block32_index == $past(check_addr[23:15])) else $error("bad block");
  a_block64_dec: assert property (!$past(sys_rst) |->
    block64_index == $past(check_addr[23:16])) else $error("bad block");
  a_quad_pins: assert property (status[6] ##1 status[6] |->
    quad_mode) else $error("quad flag off");
  a_busy_ends: assert property ($rose(status[0]) |->
    ##[1:BUSY_MAX] !status[0]) else $error("busy stuck");
  a_lock_holds: assert property (status[7] && !status[6] && !wp_n |=>
    $stable(status[7:2])) else $error("locked status changed");
  a_latch_gate: assert property (!status[1] |=>
    $stable(status[7:2])) else $error("write without latch");
  a_prot_all: assert property (!$past(sys_rst) &&
    $past(status[5:2]) >= 4'h9 |-> addr_protected) else $error("unprot");
endmodule
bind flash_status_register_map flash_status_checker u_chk (.clk(clk),
  .sys_rst(sys_rst), .wp_n(wp_n), .check_addr(check_addr),
  .status(status), .quad_mode(quad_mode), .sector_index(sector_index),
  .block32_index(block32_index), .block64_index(block64_index),
  .addr_protected(addr_protected));

// *** testbench/spi_host_model.sv ***
// Serial host model framing commands to the status block
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk, // clock
  input wire logic so, // from device
  output logic cs_n, // select
  output logic sck_rise, // rise strobe
  output logic sck_fall, // fall strobe
  output logic si // to device
);
  initial {cs_n, sck_rise, sck_fall, si} = 4'h8;
  // Read bit is taken at the rise, after the fall that shifted it out
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk) {si, sck_rise} = {tx[i], 1'h1};
      rx[i] = so;
      @(negedge clk) sck_rise = 1'h0;
      @(negedge clk) sck_fall = 1'h1;
      @(negedge clk) sck_fall = 1'h0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] d,
    input int n, output logic [7:0] rx);
    @(negedge clk) cs_n = 1'h0;
    xfer(cmd, rx);
    repeat (n - 1) xfer(d, rx);
    // Idle data line is flipped so a stale bit is never reused
    @(negedge clk) {cs_n, si} = {1'h1, ~si};
    repeat (2) @(negedge clk);
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the flash status block
`timescale 1ns/1ps
module tb;
  import flash_status_pkg::*;
  logic clk = 0, sys_rst = 1, wp_n = 1, so, quad_mode, prot;
  logic cs_n, sck_rise, sck_fall, si;
  logic pause_n = 1, so_oe, wp_act, paused;
  logic [ADDR_W-1:0] check_addr = 24'hFEF123;
  logic [7:0] status, rx;
  logic [SECTOR_W-1:0] sec;
  logic [BLK32_W-1:0] b32;
  logic [BLK64_W-1:0] b64;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  flash_status_register_map #(.WRITE_CYCLES(2)) uut (.clk(clk),
    .sys_rst(sys_rst), .cs_n(cs_n), .sck_rise(sck_rise),
    .sck_fall(sck_fall), .si(si), .wp_n(wp_n), .pause_n(pause_n),
    .check_addr(check_addr), .write_done(1'h0), .so(so), .so_oe(so_oe),
    .status(status), .quad_mode(quad_mode), .wp_active(wp_act),
    .paused(paused),
    .sector_index(sec), .block32_index(b32), .block64_index(b64),
    .addr_protected(prot));
  spi_host_model host (.clk(clk), .so(so), .cs_n(cs_n),
    .sck_rise(sck_rise), .sck_fall(sck_fall), .si(si));
  task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic settle(logic [7:0] exp);
    for (int n = 0; n < 40 && status[0] !== 1'h0; n++) @(negedge clk);
    chk("status", status, exp);
  endtask
  task automatic t_decode;
    chk("status", status, 8'h00);
    chk("sector", sec, 12'hFEF);
    chk("block32", b32, 9'h1FD);
    chk("block64", b64, 8'hFE);
    chk("wp role", wp_act, 1'h1);
    chk("paused", paused, 1'h0);
    chk("so_oe idle", so_oe, 1'h0);
  endtask
  task automatic t_reset;
    @(negedge clk) sys_rst = 1;
    @(negedge clk) sys_rst = 0;
    @(negedge clk);
    chk("reset", status, 8'h00);
    chk("latch reset", status[1], 1'h0);
    chk("quad reset", quad_mode, 1'h0);
    chk("wp reset", wp_act, 1'h1);
    chk("prot reset", prot, 1'h0);
  endtask
  task automatic t_write_read;
    host.frame(CMD_SET_WEL, 8'h00, 1, rx);
    // Latch and busy bits of the data byte must not land
    host.frame(CMD_STATUS_WRITE, 8'hA7, 2, rx);
    settle(8'hA4);
    host.frame(CMD_READ_STATUS, 8'h00, 3, rx);
    chk("read", rx, 8'hA4);
    chk("so_oe off", so_oe, 1'h0);
    chk("prot", prot, 1'h1);
  endtask
  task automatic t_lock;
    @(negedge clk) wp_n = 1'h0;
    host.frame(CMD_SET_WEL, 8'h00, 1, rx);
    host.frame(CMD_STATUS_WRITE, 8'h40, 2, rx);
    chk("locked", status, 8'hA6);
    host.frame(CMD_CLR_WEL, 8'h00, 1, rx);
    @(negedge clk) wp_n = 1'h1;
    host.frame(CMD_STATUS_WRITE, 8'h40, 2, rx);
    chk("no latch", status, 8'hA4);
    host.frame(CMD_SET_WEL, 8'h00, 1, rx);
    host.frame(CMD_STATUS_WRITE, 8'h40, 2, rx);
    settle(8'h40);
    chk("quad", quad_mode, 1'h1);
    @(negedge clk) pause_n = 1'h0;
    repeat (2) @(negedge clk);
    chk("wp data", wp_act, 1'h0);
    chk("pause data", paused, 1'h0);
    pause_n = 1'h1;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    t_decode;
    t_write_read;
    t_lock;
    t_reset;
    tally_and_finish;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      tally_and_finish;
    end
  end
endmodule
